// ===== led_reset_timer.sv
// Purpose: Status LED sequencer and reset contact hold timer
// Assumes: contact_bridged is an asynchronous pin, high when bridged
// Notes: Actions leave as one-cycle pulses for the system to perform
//
// How it works
// - While bridged, settings mode, 10 Hz blink
// - Release 0.5 to 2 s sets default address
// - Release 2 to 10 s: no action, steady LED
// - At ten seconds blinking resumes
// - Over ten seconds: factory restore, second address
// - Leaving settings mode returns to status mode
// - Flashes 0.5 s apart, 4 s dark, repeat
// - Flash count follows system status code
// - While starting, LED continuously lit
// - No network: one flash per group
// - Normal operation: two flashes per group
// - After default address or restore: three flashes
// - Restore hold restarts system on release
module led_reset_timer #(
   parameter int unsigned HOLD_MIN = led_timer_pkg::HOLD_MIN_CYC,
   parameter int unsigned HOLD_MID = led_timer_pkg::HOLD_MID_CYC,
   parameter int unsigned HOLD_LONG = led_timer_pkg::HOLD_LONG_CYC,
   parameter int unsigned FAST_HALF = led_timer_pkg::FAST_HALF_CYC,
   parameter int unsigned FLASH_GAP = led_timer_pkg::FLASH_GAP_CYC,
   parameter int unsigned DARK = led_timer_pkg::DARK_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic contact_bridged,
   input wire logic [1:0] sys_status,
   output logic led_on,
   output logic settings_mode,
   output logic set_default_addr,
   output logic factory_restore,
   output logic add_second_addr,
   output logic restart_system,
   output logic [31:0] default_addr
);
   initial begin
      if (!(HOLD_MIN < HOLD_MID && HOLD_MID < HOLD_LONG)) begin
         $error("hold thresholds must rise");
      end
      if (FLASH_GAP < 2 || DARK < 1 || FAST_HALF < 2) begin
         $error("LED timing too short");
      end
   end

   // ---------------------------------------------------------------
   // Contact synchroniser
   // ---------------------------------------------------------------
   logic sync1_reg, sync2_reg, bridged_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= led_timer_pkg::CONTACT_SYNC_RESET;
         sync2_reg <= led_timer_pkg::CONTACT_SYNC_RESET;
         bridged_reg <= led_timer_pkg::CONTACT_SYNC_RESET;
      end else begin
         sync1_reg <= contact_bridged;
         sync2_reg <= sync1_reg;
         bridged_reg <= sync2_reg;
      end
   end
   wire logic press = sync2_reg && !bridged_reg;
   wire logic release_ev = !sync2_reg && bridged_reg;

   // ---------------------------------------------------------------
   // Hold duration counter
   // ---------------------------------------------------------------
   // Saturates past the long threshold so a very long hold cannot wrap
   localparam int unsigned HW = $clog2(HOLD_LONG + 2);
   logic [HW-1:0] hold_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_reg <= '0;
      end else if (press) begin
         hold_reg <= '0;
      end else if (bridged_reg && hold_reg <= HW'(HOLD_LONG)) begin
         hold_reg <= hold_reg + HW'(1);
      end
   end
   wire logic hold_steady = hold_reg >= HW'(HOLD_MID) &&
      hold_reg < HW'(HOLD_LONG);

   // ---------------------------------------------------------------
   // Release decision and action pulses
   // ---------------------------------------------------------------
   logic defaulted_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         set_default_addr <= 1'b0;
         factory_restore <= 1'b0;
         add_second_addr <= 1'b0;
         restart_system <= 1'b0;
         defaulted_reg <= 1'b0;
      end else begin
         set_default_addr <= 1'b0;
         factory_restore <= 1'b0;
         add_second_addr <= 1'b0;
         restart_system <= 1'b0;
         if (release_ev) begin
            if (hold_reg > HW'(HOLD_LONG)) begin
               factory_restore <= 1'b1;
               add_second_addr <= 1'b1;
               restart_system <= 1'b1;
               defaulted_reg <= 1'b1;
            end else if (hold_reg >= HW'(HOLD_MIN) &&
                         hold_reg <= HW'(HOLD_MID)) begin
               set_default_addr <= 1'b1;
               defaulted_reg <= 1'b1;
            end
            // Short or mid holds fall through with no action
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         default_addr <= led_timer_pkg::ADDR_RESET;
         settings_mode <= 1'b0;
      end else begin
         default_addr <= led_timer_pkg::DEFAULT_ADDR;
         settings_mode <= bridged_reg;
      end
   end

   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   logic fast_tick, gap_tick;
   pulse_timer #(.PERIOD(FAST_HALF), .W(32)) u_fast (
      .clk(clk),
      .nrst(nrst),
      .restart(press),
      .tick(fast_tick)
   );
   logic fast_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fast_reg <= 1'b1;
      end else if (press) begin
         fast_reg <= 1'b1;
      end else if (fast_tick) begin
         fast_reg <= !fast_reg;
      end
   end

   // ---------------------------------------------------------------
   // Status flash sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {S_FLASH, S_GAP, S_DARK} seq_t;
   seq_t seq_reg;
   localparam int unsigned SW = $clog2(DARK + FLASH_GAP + 1);
   localparam int unsigned HALF_GAP = FLASH_GAP / 2;
   logic [SW-1:0] tmr_reg;
   logic [1:0] left_reg;

   // Status code to flash count; starting gives 0 and beats the sticky
   // defaulted flag, since a restore restarts the system
   function automatic logic [1:0] flashes(input logic [1:0] st,
                                          input logic dflt);
      logic [1:0] n;
      n = 2'h0;
      if (st == led_timer_pkg::ST_STARTING) begin
         n = 2'h0;
      end else if (dflt) begin
         n = led_timer_pkg::FLASH_DEFAULTED;
      end else begin
         case (st)
            led_timer_pkg::ST_NO_NET: begin
               n = led_timer_pkg::FLASH_NO_NET;
            end
            led_timer_pkg::ST_NORMAL: begin
               n = led_timer_pkg::FLASH_NORMAL;
            end
            led_timer_pkg::ST_DEFAULTED: n = led_timer_pkg::FLASH_DEFAULTED;
            default: n = 2'h0;
         endcase
      end
      return n;
   endfunction

   wire logic [1:0] want = flashes(sys_status, defaulted_reg);

   // Each flash is lit for half the 0.5 s spacing, then dark the rest
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seq_reg <= S_DARK;
         tmr_reg <= '0;
         left_reg <= 2'h0;
      end else if (bridged_reg) begin
         seq_reg <= S_DARK;
         tmr_reg <= '0;
         left_reg <= 2'h0;
      end else begin
         case (seq_reg)
            S_FLASH: begin
               if (tmr_reg == SW'(HALF_GAP - 1)) begin
                  seq_reg <= S_GAP;
               end
               tmr_reg <= tmr_reg + SW'(1);
            end
            S_GAP: begin
               if (tmr_reg == SW'(FLASH_GAP - 1)) begin
                  tmr_reg <= '0;
                  if (left_reg > 2'h1) begin
                     left_reg <= left_reg - 2'h1;
                     seq_reg <= S_FLASH;
                  end else begin
                     left_reg <= 2'h0;
                     seq_reg <= S_DARK;
                  end
               end else begin
                  tmr_reg <= tmr_reg + SW'(1);
               end
            end
            S_DARK: begin
               if (tmr_reg >= SW'(DARK - 1) && want != 2'h0) begin
                  tmr_reg <= '0;
                  left_reg <= want;
                  seq_reg <= S_FLASH;
               end else if (tmr_reg < SW'(DARK - 1)) begin
                  tmr_reg <= tmr_reg + SW'(1);
               end
            end
            default: begin
               seq_reg <= S_DARK;
               tmr_reg <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // LED drive
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         led_on <= 1'b1;
      end else if (bridged_reg) begin
         led_on <= hold_steady ? 1'b1 : fast_reg;
      end else if (want == 2'h0) begin
         led_on <= 1'b1;
      end else begin
         led_on <= seq_reg == S_FLASH;
      end
   end
endmodule

// ===== led_timer_pkg.sv
// Purpose: Constants for the status LED and reset contact timer
// Assumes: 25 MHz system clock
// Notes: Times are kept in their own units; cycle counts derive from them
package led_timer_pkg;
   // ---------------------------------------------------------------
   // Clock and times
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned FAST_BLINK_HZ = 10;
   localparam int unsigned HOLD_MIN_MS = 500;
   localparam int unsigned HOLD_MID_MS = 2000;
   localparam int unsigned HOLD_LONG_MS = 10000;
   localparam int unsigned FLASH_GAP_MS = 500;
   localparam int unsigned DARK_MS = 4000;
   localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
   localparam int unsigned HOLD_MIN_CYC = (CLK_HZ / 1000) * HOLD_MIN_MS;
   localparam int unsigned HOLD_MID_CYC = (CLK_HZ / 1000) * HOLD_MID_MS;
   localparam int unsigned HOLD_LONG_CYC = (CLK_HZ / 1000) * HOLD_LONG_MS;
   localparam int unsigned FLASH_GAP_CYC = (CLK_HZ / 1000) * FLASH_GAP_MS;
   localparam int unsigned DARK_CYC = (CLK_HZ / 1000) * DARK_MS;
   // ---------------------------------------------------------------
   // Status codes and flash counts
   // ---------------------------------------------------------------
   localparam logic [1:0] ST_STARTING = 2'h0;
   localparam logic [1:0] ST_NO_NET = 2'h1;
   localparam logic [1:0] ST_NORMAL = 2'h2;
   localparam logic [1:0] ST_DEFAULTED = 2'h3;
   localparam logic [1:0] FLASH_NO_NET = 2'h1;
   localparam logic [1:0] FLASH_NORMAL = 2'h2;
   localparam logic [1:0] FLASH_DEFAULTED = 2'h3;
   // ---------------------------------------------------------------
   // Default address and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] DEFAULT_ADDR = 32'hC0A86F47;
   localparam logic [31:0] ADDR_RESET = 32'h00000000;
   localparam logic CONTACT_SYNC_RESET = 1'h0;
endpackage

// ===== pulse_timer.sv
// Purpose: Free-running period tick generator with restart
// Assumes: PERIOD at least 2
// Notes: First tick comes PERIOD-1 cycles after restart, so a registered
// follower toggles exactly PERIOD cycles after the restart edge
module pulse_timer #(
   parameter int unsigned PERIOD = 2,
   parameter int unsigned W = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic restart,
   output logic tick
);
   initial begin
      if (PERIOD < 2 || PERIOD >= (64'h1 << W)) begin
         $error("pulse_timer PERIOD out of range");
      end
   end
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);
   logic [W-1:0] cnt_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (restart) begin
         cnt_reg <= W'(1);
         tick <= 1'b0;
      end else if (cnt_reg == LAST) begin
         cnt_reg <= '0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + W'(1);
         tick <= 1'b0;
      end
   end
endmodule

// ===== led_reset_timer_props.sv
// Purpose: Port assertions for led_reset_timer
// Assumes: One clock, nrst asynchronous and active low
// Notes: Fast blink spacing is fixed at a half period of 5 cycles
module led_reset_timer_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic contact_bridged,
   input wire logic [1:0] sys_status,
   input wire logic led_on,
   input wire logic settings_mode,
   input wire logic set_default_addr,
   input wire logic factory_restore,
   input wire logic add_second_addr,
   input wire logic restart_system,
   input wire logic [31:0] default_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_toggle;
      settings_mode && $changed(led_on);
   endsequence
   sequence s_starting;
      (!settings_mode && sys_status == led_timer_pkg::ST_STARTING)[*3];
   endsequence
   property p_fast;
      s_toggle |=> (!settings_mode || $stable(led_on))[*4];
   endproperty
   property p_enter_lit;
      $rose(settings_mode) |-> ##[0:1] led_on;
   endproperty
   property p_start_lit;
      s_starting |-> led_on;
   endproperty
   property p_set_once;
      set_default_addr |=> !set_default_addr && !factory_restore;
   endproperty
   property p_excl;
      set_default_addr |-> !factory_restore && !restart_system;
   endproperty
   property p_restore_pair;
      factory_restore |-> add_second_addr && restart_system;
   endproperty
   property p_restore_once;
      factory_restore |=> !factory_restore;
   endproperty
   property p_restart;
      restart_system |-> factory_restore;
   endproperty
   property p_addr;
      $past(nrst) |-> default_addr == led_timer_pkg::DEFAULT_ADDR;
   endproperty
   a_fast: assert property (p_fast)
      else $error("fast blink too quick");
   a_enter_lit: assert property (p_enter_lit)
      else $error("settings entry not lit");
   a_start_lit: assert property (p_start_lit)
      else $error("starting led not lit");
   a_set_once: assert property (p_set_once)
      else $error("default address pulse too long");
   a_excl: assert property (p_excl)
      else $error("default address with restore");
   a_restore_pair: assert property (p_restore_pair)
      else $error("restore without second address");
   a_restore_once: assert property (p_restore_once)
      else $error("restore pulse too long");
   a_restart: assert property (p_restart)
      else $error("restart without restore");
   a_addr: assert property (p_addr)
      else $error("default address wrong");
endmodule
bind led_reset_timer led_reset_timer_props u_props (.clk, .nrst,
   .contact_bridged, .sys_status, .led_on, .settings_mode,
   .set_default_addr, .factory_restore, .add_second_addr,
   .restart_system, .default_addr);

// ===== contact_person.sv
// Purpose: Person bridging the reset contact
// Assumes: Presses are whole cycles long
// Notes: Pin changes only at falling edges, like a slow hand
module contact_person (
   input wire logic clk,
   output logic contact_bridged
);
   timeunit 1ns;
   timeprecision 1ps;
   initial contact_bridged = 1'b0;
   task automatic press(input int n);
      @(negedge clk);
      contact_bridged = 1'b1;
      repeat (n) @(negedge clk);
      contact_bridged = 1'b0;
   endtask
endmodule

// ===== status_led_and_reset_contact_timer_tb.sv
// Purpose: Self-checking bench for led_reset_timer
// Assumes: Shortened counts 10,40,200,5,20,80
// Notes: Flash and blink times judged from the LED pin only
module status_led_and_reset_contact_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FH = 5;
   localparam int FG = 20;
   localparam int DK = 80;
   localparam int HL = 200;
   logic clk, nrst, led_on, settings_mode, set_default_addr;
   logic factory_restore, add_second_addr, restart_system, led_d;
   logic [1:0] sys_status;
   logic [31:0] default_addr;
   wire logic contact_bridged;
   int fails = 0, n_tests = 0, cyc = 0, pc = 0, tog, run = 0;
   int maxrun, late, n_set, n_rst, n_sec, n_rs;
   led_reset_timer #(.HOLD_MIN(10), .HOLD_MID(40), .HOLD_LONG(HL),
      .FAST_HALF(FH), .FLASH_GAP(FG), .DARK(DK)) DUT (.clk, .nrst,
      .contact_bridged, .sys_status, .led_on, .settings_mode,
      .set_default_addr, .factory_restore, .add_second_addr,
      .restart_system, .default_addr);
   contact_person person (.clk, .contact_bridged);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task final_report;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // ---------------------------------------------------------------
   // Monitor and timeout
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      pc = contact_bridged ? pc + 1 : 0;
      if (settings_mode === 1'b1 && led_on !== led_d) begin
         tog++;
         if (pc > HL + 15) late++;
      end
      run = (led_on && settings_mode) ? run + 1 : 0;
      if (run > maxrun) maxrun = run;
      led_d = led_on;
      n_set += int'(set_default_addr);
      n_rst += int'(factory_restore);
      n_sec += int'(add_second_addr);
      n_rs += int'(restart_system);
      if (cyc == 10000) begin
         fails++;
         final_report();
      end
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_start;
      int off = 0;
      repeat (200) begin
         @(negedge clk);
         if (led_on !== 1'b1) off++;
      end
      check(32'(off), 32'h0);
      check(default_addr, led_timer_pkg::DEFAULT_ADDR);
   endtask
   task automatic t_status(input logic [1:0] code, input int n);
      int low, rises, t0, t1;
      @(negedge clk);
      sys_status = code;
      low = 0;
      while (low < 50) begin
         @(negedge clk);
         low = led_on ? 0 : low + 1;
      end
      while (!led_on) @(negedge clk);
      rises = 1;
      t0 = cyc;
      t1 = 0;
      low = 0;
      while (low < 50) begin
         @(negedge clk);
         if (led_on && low > 0) begin
            rises++;
            if (rises == 2) t1 = cyc;
         end
         low = led_on ? 0 : low + 1;
      end
      while (!led_on) begin
         @(negedge clk);
         low++;
      end
      check(32'(rises), 32'(n));
      if (n > 1) check(32'(t1 - t0), 32'(FG));
      check(32'(low >= DK), 32'h1);
   endtask
   task automatic t_press(input int n, input int es, input int er);
      n_set = 0;
      n_rst = 0;
      n_sec = 0;
      n_rs = 0;
      tog = 0;
      late = 0;
      maxrun = 0;
      person.press(n);
      repeat (10) @(negedge clk);
      check(32'(n_set), 32'(es));
      check(32'(n_rst), 32'(er));
      check(32'(n_sec), 32'(er));
      check(32'(n_rs), 32'(er));
      check({31'h0, settings_mode}, 32'h0);
      if (n == 25) check(32'(tog >= 3 && maxrun <= FH), 32'h1);
      if (n == 100) check(32'(maxrun >= 50), 32'h1);
      if (n == 300) check(32'(late >= 5), 32'h1);
   endtask
   initial begin
      nrst = 1'b0;
      sys_status = 2'h0;
      led_d = 1'b1;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      t_start();
      t_status(2'h1, 1);
      t_status(2'h2, 2);
      t_status(2'h3, 3);
      t_press(5, 0, 0);
      t_press(25, 1, 0);
      t_press(100, 0, 0);
      t_press(300, 0, 1);
      // Defaulted indication sticks even with normal status
      t_status(2'h2, 3);
      final_report();
   end
endmodule
